// File: cpu_exception_mode_unit.sv
// Exception entry, privilege modes, stack pointers and bus status of a 16-bit core.
// Assumes the core issues one instruction at a time and holds off while busy_out is high,
// and that memory answers each mem_req_out with one mem_ack_in on this clock.

module cpu_exception_mode_unit
  import exc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Interrupt and abort pins, active low
  input  wire logic        nmi_n_in,
  input  wire logic        nvi_n_in,
  input  wire logic        vi_n_in,
  input  wire logic        abort_n_in,
  // Core issue port
  input  wire logic        instr_valid_in,
  input  wire logic        instr_restricted_in,
  input  wire logic        instr_syscall_in,
  input  wire logic [7:0]  syscall_code_in,
  input  wire logic        instr_ldps_in,
  input  wire logic [15:0] ldps_fcw_in,
  input  wire logic [15:0] ldps_pc_in,
  input  wire logic        instr_pushpop_in,
  input  wire logic [3:0]  instr_stack_reg_in,
  input  wire logic [15:0] short_word_in,
  input  wire logic        irq_window_in,
  input  wire logic [15:0] instr_pc_in,
  input  wire logic [15:0] next_pc_in,
  // Core register writes
  input  wire logic        flags_wr_in,
  input  wire logic [7:0]  flags_in,
  input  wire logic        sp_wr_in,
  input  wire logic [15:0] sp_wdata_in,
  input  wire logic        psap_wr_in,
  input  wire logic [15:0] psap_wdata_in,
  // Core access status
  input  wire logic        core_acc_in,
  input  wire logic        core_acc_instr_in,
  input  wire logic        core_acc_stack_in,
  input  wire logic        sema_active_in,
  // Core results
  output logic             busy_out,
  output logic             pc_load_out,
  output logic [15:0]      pc_new_out,
  output logic [15:0]      fcw_out,
  output logic             sys_mode_out,
  output logic [15:0]      sp_out,
  output logic             stack_reg_ok_out,
  output logic [6:0]       short_seg_out,
  output logic [15:0]      short_off_out,
  // Memory and acknowledge port
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [15:0]      mem_addr_out,
  output logic [15:0]      mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic [15:0] mem_rdata_in,
  output bus_st_t          bus_status_out
);
  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    return 16'(a + b);
  endfunction

  exc_decode_if dec ();
  priv_check u_chk (.dec(dec));

  // Two-flop synchronisers for the four pins
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       nmi_lvl_r;
  logic       abort_lvl_r;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
    end else begin
      sync1_r <= {abort_n_in, vi_n_in, nvi_n_in, nmi_n_in};
      sync2_r <= sync1_r;
    end
  end
  wire nmi_act   = !sync2_r[0];
  wire nvi_act   = !sync2_r[1];
  wire vi_act    = !sync2_r[2];
  wire abort_act = !sync2_r[3];

  ent_st_t     st_r, st_nxt;
  ent_kind_t   kind_r, kind_nxt;
  logic [15:0] fcw_r, fcw_nxt;
  logic [15:0] sp_sys_r, sp_sys_nxt;
  logic [15:0] sp_norm_r, sp_norm_nxt;
  logic [15:0] psap_r, psap_nxt;
  logic [15:0] save_pc_r, save_pc_nxt;
  logic [15:0] save_fcw_r, save_fcw_nxt;
  logic [15:0] reason_r, reason_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] pc_new_r, pc_new_nxt;
  logic        pc_load_r, pc_load_nxt;
  logic        nmi_pend_r, abort_pend_r;

  wire idle     = st_r == ST_IDLE;
  wire sys_mode = fcw_r[FCW_SYS_BIT];

  assign dec.sys_mode    = sys_mode;
  assign dec.instr_valid = instr_valid_in & idle;
  assign dec.restricted  = instr_restricted_in;
  assign dec.syscall     = instr_syscall_in;
  assign dec.ldps        = instr_ldps_in;
  assign dec.pushpop     = instr_pushpop_in;
  assign dec.stack_reg   = instr_stack_reg_in;
  assign dec.short_word  = short_word_in;

  // NMI and abort are edge-caught, the vectored interrupts are levels; a new edge in the clearing cycle stays pending
  wire nmi_edge   = nmi_act & !nmi_lvl_r;
  wire abort_edge = abort_act & !abort_lvl_r;
  wire vi_ok      = vi_act & fcw_r[FCW_VIE_BIT];
  wire nvi_ok     = nvi_act & fcw_r[FCW_NVIE_BIT];
  wire irq_go     = irq_window_in & (nmi_pend_r | vi_ok | nvi_ok);
  wire start      = idle & (abort_pend_r | dec.priv_trap | dec.syscall_go | irq_go);
  wire take_int   = !abort_pend_r & !dec.priv_trap & !dec.syscall_go;
  wire ack_now    = mem_ack_in & !idle;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nmi_lvl_r    <= 1'b0;
      abort_lvl_r  <= 1'b0;
      nmi_pend_r   <= 1'b0;
      abort_pend_r <= 1'b0;
    end else begin
      nmi_lvl_r    <= nmi_act;
      abort_lvl_r  <= abort_act;
      nmi_pend_r   <= nmi_edge | (nmi_pend_r & !(start & take_int & kind_nxt == ENT_NMI));
      abort_pend_r <= abort_edge | (abort_pend_r & !start);
    end
  end

  // Entry class selection by priority
  always_comb begin
    kind_nxt = kind_r;
    if (start) begin
      if (abort_pend_r)          kind_nxt = ENT_ABORT;
      else if (dec.priv_trap)    kind_nxt = ENT_PRIV;
      else if (dec.syscall_go)   kind_nxt = ENT_SYSCALL;
      else if (nmi_pend_r)       kind_nxt = ENT_NMI;
      else if (vi_ok)            kind_nxt = ENT_VI;
      else                       kind_nxt = ENT_NVI;
    end
  end
  wire is_irq = kind_nxt == ENT_NMI || kind_nxt == ENT_VI || kind_nxt == ENT_NVI;

  // Sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:     if (start) st_nxt = is_irq ? ST_IACK : ST_PUSH_PC;
      ST_IACK:     if (mem_ack_in) st_nxt = ST_PUSH_PC;
      ST_PUSH_PC:  if (mem_ack_in) st_nxt = ST_PUSH_FCW;
      ST_PUSH_FCW: if (mem_ack_in) st_nxt = ST_PUSH_RSN;
      ST_PUSH_RSN: if (mem_ack_in) st_nxt = ST_LD_FCW;
      ST_LD_FCW:   if (mem_ack_in) st_nxt = ST_LD_PC;
      ST_LD_PC:    if (mem_ack_in) st_nxt = ST_IDLE;
      default:     st_nxt = ST_IDLE;
    endcase
  end

  // Saved status; abort and privileged trap restart at the faulting instruction
  wire        restart_pc = kind_nxt == ENT_ABORT || kind_nxt == ENT_PRIV;
  assign save_pc_nxt  = start ? (restart_pc ? instr_pc_in : next_pc_in) : save_pc_r;
  assign save_fcw_nxt = start ? fcw_r : save_fcw_r;

  always_comb begin
    reason_nxt = reason_r;
    if (start) begin
      case (kind_nxt)
        ENT_ABORT:   reason_nxt = RSN_ABORT;
        ENT_PRIV:    reason_nxt = RSN_PRIV;
        ENT_SYSCALL: reason_nxt = {RSN_SC_HI, syscall_code_in};
        default:     reason_nxt = reason_r;
      endcase
    end else if (st_r == ST_IACK && mem_ack_in) begin
      reason_nxt = mem_rdata_in;
    end
  end

  // Entry offset into the status area
  logic [15:0] ent_off;
  always_comb begin
    case (kind_r)
      ENT_ABORT:   ent_off = PSA_ABORT;
      ENT_PRIV:    ent_off = PSA_PRIV;
      ENT_SYSCALL: ent_off = PSA_SYSCALL;
      ENT_NMI:     ent_off = PSA_NMI;
      ENT_VI:      ent_off = PSA_VI;
      default:     ent_off = PSA_NVI;
    endcase
  end
  wire [15:0] fcw_addr = add16(psap_r, ent_off);
  wire [15:0] vec_idx  = {7'h00, reason_r[7:0], 1'b0};
  wire [15:0] pc_addr  = (kind_r == ENT_VI) ? add16(add16(psap_r, PSA_VEC_TBL), vec_idx)
                                            : add16(fcw_addr, PSA_PC_OFF);

  // Stack pointers; entry always walks the system stack
  wire push_ack = ack_now && (st_r == ST_PUSH_PC || st_r == ST_PUSH_FCW ||
                              st_r == ST_PUSH_RSN);
  always_comb begin
    sp_sys_nxt  = sp_sys_r;
    sp_norm_nxt = sp_norm_r;
    if (push_ack)
      sp_sys_nxt = 16'(sp_sys_r - WORD_BYTES);
    else if (idle && sp_wr_in && sys_mode)
      sp_sys_nxt = sp_wdata_in;
    else if (idle && sp_wr_in)
      sp_norm_nxt = sp_wdata_in;
  end

  // Address and data of the access about to start
  always_comb begin
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    case (st_nxt)
      ST_PUSH_PC: begin
        addr_nxt  = 16'(sp_sys_nxt - WORD_BYTES);
        wdata_nxt = save_pc_nxt;
      end
      ST_PUSH_FCW: begin
        addr_nxt  = 16'(sp_sys_nxt - WORD_BYTES);
        wdata_nxt = save_fcw_nxt;
      end
      ST_PUSH_RSN: begin
        addr_nxt  = 16'(sp_sys_nxt - WORD_BYTES);
        wdata_nxt = reason_nxt;
      end
      ST_LD_FCW: addr_nxt = fcw_addr;
      ST_LD_PC:  addr_nxt = pc_addr;
      default:   addr_nxt = addr_r;
    endcase
  end

  // Status word and program counter loads
  always_comb begin
    fcw_nxt     = fcw_r;
    pc_new_nxt  = pc_new_r;
    pc_load_nxt = 1'b0;
    if (st_r == ST_LD_FCW && mem_ack_in) begin
      fcw_nxt = mem_rdata_in;
    end else if (st_r == ST_LD_PC && mem_ack_in) begin
      pc_new_nxt  = mem_rdata_in;
      pc_load_nxt = 1'b1;
    end else if (dec.ldps_go) begin
      fcw_nxt     = ldps_fcw_in;
      pc_new_nxt  = ldps_pc_in;
      pc_load_nxt = 1'b1;
    end else if (idle && flags_wr_in) begin
      fcw_nxt = {fcw_r[15:8], flags_in};
    end
  end
  assign psap_nxt = (idle && psap_wr_in && sys_mode) ? psap_wdata_in : psap_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r       <= ST_IDLE;
      kind_r     <= ENT_NVI;
      fcw_r      <= FCW_RESET;
      sp_sys_r   <= SP_RESET;
      sp_norm_r  <= SP_RESET;
      psap_r     <= PSAP_RESET;
      save_pc_r  <= 16'h0000;
      save_fcw_r <= 16'h0000;
      reason_r   <= 16'h0000;
      addr_r     <= 16'h0000;
      wdata_r    <= 16'h0000;
      pc_new_r   <= 16'h0000;
      pc_load_r  <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      kind_r     <= kind_nxt;
      fcw_r      <= fcw_nxt;
      sp_sys_r   <= sp_sys_nxt;
      sp_norm_r  <= sp_norm_nxt;
      psap_r     <= psap_nxt;
      save_pc_r  <= save_pc_nxt;
      save_fcw_r <= save_fcw_nxt;
      reason_r   <= reason_nxt;
      addr_r     <= addr_nxt;
      wdata_r    <= wdata_nxt;
      pc_new_r   <= pc_new_nxt;
      pc_load_r  <= pc_load_nxt;
    end
  end

  // Bus status: own accesses first, then the core's
  wire pushing = st_r == ST_PUSH_PC || st_r == ST_PUSH_FCW || st_r == ST_PUSH_RSN;
  always_comb begin
    if (st_r == ST_IACK)
      bus_status_out = (kind_r == ENT_NMI) ? BST_IACK_NMI :
                       (kind_r == ENT_VI)  ? BST_IACK_VI  : BST_IACK_NVI;
    else if (pushing)
      bus_status_out = BST_STACK;
    else if (!idle)
      bus_status_out = BST_DATA;
    else if (core_acc_in && sema_active_in)
      bus_status_out = BST_SEMA;
    else if (core_acc_in)
      bus_status_out = core_acc_instr_in ? BST_INSTR :
                       core_acc_stack_in ? BST_STACK : BST_DATA;
    else
      bus_status_out = BST_IDLE;
  end

  assign busy_out         = !idle;
  assign pc_load_out      = pc_load_r;
  assign pc_new_out       = pc_new_r;
  assign fcw_out          = fcw_r;
  assign sys_mode_out     = sys_mode;
  assign sp_out           = sys_mode ? sp_sys_r : sp_norm_r;
  assign stack_reg_ok_out = dec.stack_reg_ok;
  assign short_seg_out    = dec.short_seg;
  assign short_off_out    = dec.short_off;
  assign mem_req_out      = !idle;
  assign mem_we_out       = pushing;
  assign mem_addr_out     = addr_r;
  assign mem_wdata_out    = wdata_r;
endmodule

// File: exc_pkg.sv
// Constants, state codes and status layout of the exception and mode unit.
// Assumes 16-bit words and byte addresses on the memory port.
package exc_pkg;
  localparam int                 WORD_W       = 16;
  localparam logic [15:0]        WORD_BYTES   = 16'h0002;
  // Program status word: control bits high byte, flags low byte
  localparam int                 FCW_SYS_BIT  = 14;
  localparam int                 FCW_VIE_BIT  = 12;
  localparam int                 FCW_NVIE_BIT = 11;
  localparam logic [15:0]        FCW_RESET    = 16'h4000;
  localparam logic [15:0]        SP_RESET     = 16'h0000;
  localparam logic [15:0]        PSAP_RESET   = 16'h0000;
  // Entry offsets in the status area: control word, then handler address
  localparam logic [15:0]        PSA_ABORT    = 16'h0004;
  localparam logic [15:0]        PSA_PRIV     = 16'h0008;
  localparam logic [15:0]        PSA_SYSCALL  = 16'h000C;
  localparam logic [15:0]        PSA_NMI      = 16'h0014;
  localparam logic [15:0]        PSA_NVI      = 16'h0018;
  localparam logic [15:0]        PSA_VI       = 16'h001C;
  localparam logic [15:0]        PSA_VEC_TBL  = 16'h0020;
  localparam logic [15:0]        PSA_PC_OFF   = 16'h0002;
  // Reason codes for internally raised entries
  localparam logic [15:0]        RSN_ABORT    = 16'hA000;
  localparam logic [15:0]        RSN_PRIV     = 16'hB000;
  localparam logic [7:0]         RSN_SC_HI    = 8'h7F;
  // Bus status codes
  typedef enum logic [3:0] {
    BST_IDLE     = 4'h0,
    BST_IACK_NMI = 4'h1,
    BST_IACK_NVI = 4'h2,
    BST_IACK_VI  = 4'h3,
    BST_SEMA     = 4'h4,
    BST_DATA     = 4'h8,
    BST_STACK    = 4'h9,
    BST_INSTR    = 4'hD
  } bus_st_t;
  typedef enum logic [2:0] {
    ENT_ABORT, ENT_PRIV, ENT_SYSCALL, ENT_NMI, ENT_VI, ENT_NVI
  } ent_kind_t;
  // Entry sequence, Gray coded from ST_IDLE through ST_IACK to ST_LD_PC
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_IACK     = 3'b001,
    ST_PUSH_PC  = 3'b011,
    ST_PUSH_FCW = 3'b010,
    ST_PUSH_RSN = 3'b110,
    ST_LD_FCW   = 3'b111,
    ST_LD_PC    = 3'b101
  } ent_st_t;
endpackage

// File: exc_decode_if.sv
// Interface between the entry sequencer and the instruction privilege checker.
// Assumes both ends sit on the same clock.
interface exc_decode_if;
  logic        sys_mode;
  logic        instr_valid;
  logic        restricted;
  logic        syscall;
  logic        ldps;
  logic        pushpop;
  logic [3:0]  stack_reg;
  logic [15:0] short_word;
  logic        priv_trap;
  logic        syscall_go;
  logic        ldps_go;
  logic        stack_reg_ok;
  logic [6:0]  short_seg;
  logic [15:0] short_off;
  modport unit (output sys_mode, instr_valid, restricted, syscall, ldps, pushpop,
                output stack_reg, short_word,
                input  priv_trap, syscall_go, ldps_go, stack_reg_ok, short_seg,
                input  short_off);
  modport chk  (input  sys_mode, instr_valid, restricted, syscall, ldps, pushpop,
                input  stack_reg, short_word,
                output priv_trap, syscall_go, ldps_go, stack_reg_ok, short_seg,
                output short_off);
endinterface

// File: priv_check.sv
// Privilege check and operand-form decode of the issued instruction.
// Assumes the issue strobe and fields come from logic on the same clock.
module priv_check
  import exc_pkg::*;
(
  exc_decode_if.chk dec
);
  function automatic logic sp_reg_ok(input logic [3:0] r);
    return r != 4'h0;
  endfunction

  wire         normal_mode = !dec.sys_mode;
  // Load-status is itself restricted, so it never passes in normal mode
  wire         is_restr    = dec.restricted | dec.ldps;
  wire         trap_hit    = dec.instr_valid & is_restr & normal_mode;

  assign dec.priv_trap    = trap_hit;
  assign dec.syscall_go   = dec.instr_valid & dec.syscall & !trap_hit;
  assign dec.ldps_go      = dec.instr_valid & dec.ldps & dec.sys_mode;
  // Register zero cannot serve as stack pointer
  assign dec.stack_reg_ok = !dec.pushpop | sp_reg_ok(dec.stack_reg);
  // One word carries segment number and an 8-bit offset
  assign dec.short_seg    = dec.short_word[14:8];
  assign dec.short_off    = {8'h00, dec.short_word[7:0]};
endmodule

// File: exc_unit_sva.sv
// Concurrent checks on the ports of the exception and mode unit.
// Assumes one clock and the asynchronous active-low reset.
module exc_unit_sva
  import exc_pkg::*;
(
  // Clock, reset and core side
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        instr_valid_in,
  input wire logic        instr_restricted_in,
  input wire logic        instr_ldps_in,
  input wire logic        instr_pushpop_in,
  input wire logic [3:0]  instr_stack_reg_in,
  input wire logic        irq_window_in,
  input wire logic [15:0] instr_pc_in,
  input wire logic [15:0] ldps_fcw_in,
  input wire logic [15:0] ldps_pc_in,
  input wire logic        sema_active_in,
  input wire logic        core_acc_in,
  // Results
  input wire logic        busy_out,
  input wire logic        pc_load_out,
  input wire logic [15:0] pc_new_out,
  input wire logic [15:0] fcw_out,
  input wire logic        sys_mode_out,
  input wire logic        stack_reg_ok_out,
  // Memory port
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic        mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  input bus_st_t          bus_status_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence last_read_s;
    mem_req_out && !mem_we_out && mem_ack_in ##1 !busy_out;
  endsequence
  sequence push_step_s;
    mem_we_out && mem_ack_in ##1 mem_we_out;
  endsequence
  sequence trap_req_s;
    !busy_out && instr_valid_in && instr_restricted_in && !sys_mode_out;
  endsequence

  req_hold_a: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
      && $stable(mem_wdata_out) && $stable(bus_status_out))
    else $error("memory request changed before acknowledge");
  push_down_a: assert property (
    push_step_s |-> mem_addr_out == $past(mem_addr_out) - WORD_BYTES)
    else $error("push address did not step down by one word");
  push_kind_a: assert property (
    mem_we_out |-> bus_status_out == BST_STACK)
    else $error("push without stack status");
  pc_from_area_a: assert property (
    last_read_s |-> pc_load_out && pc_new_out == $past(mem_rdata_in))
    else $error("new pc not taken from last read");
  priv_trap_a: assert property (
    trap_req_s |=> mem_we_out && mem_wdata_out == $past(instr_pc_in))
    else $error("restricted instruction did not trap");
  load_status_a: assert property (
    !busy_out && instr_valid_in && instr_ldps_in && sys_mode_out && !irq_window_in
      |=> pc_load_out && pc_new_out == $past(ldps_pc_in) && fcw_out == $past(ldps_fcw_in))
    else $error("load status did not replace status");
  sema_code_a: assert property (
    !busy_out && core_acc_in && sema_active_in |-> bus_status_out == BST_SEMA)
    else $error("semaphore status missing");
  stack_reg_a: assert property (
    stack_reg_ok_out == !(instr_pushpop_in && instr_stack_reg_in == 4'h0))
    else $error("stack register check wrong");
endmodule

bind cpu_exception_mode_unit exc_unit_sva exc_unit_sva_inst (.*);

// File: exc_far_model.sv
// Far-side model: interrupting peripheral and memory behind the MMU.
// Assumes each request is held until acknowledged; reads return 0x4000 plus address, acknowledge cycles the vector.
module exc_far_model
  import exc_pkg::*;
(
  // Clock, reset and unit memory port
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic [15:0] mem_wdata_in,
  input  bus_st_t          bus_status_in,
  // Bench controls
  input  wire logic [15:0] vector_in,
  input  wire logic [1:0]  wait_in,
  // Answers
  output logic             mem_ack_out,
  output logic [15:0]      mem_rdata_out
);
  logic [1:0]  cnt_r;
  logic [15:0] wdat_q[$];
  logic [15:0] wadr_q[$];
  wire         iack = bus_status_in inside {BST_IACK_NMI, BST_IACK_NVI, BST_IACK_VI};

  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r         <= 2'h0;
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= 16'h0000;
    end else if (mem_req_in && !mem_ack_out && cnt_r == wait_in) begin
      mem_ack_out   <= 1'b1;
      cnt_r         <= 2'h0;
      mem_rdata_out <= iack ? vector_in : 16'h4000 + mem_addr_in;
      if (mem_we_in) begin
        wdat_q.push_back(mem_wdata_in);
        wadr_q.push_back(mem_addr_in);
      end
    end else begin
      mem_ack_out   <= 1'b0;
      // Stale data flips so it never passes for a fresh answer
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in && !mem_ack_out) cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the exception and mode unit.
// Assumes the far-side model answers all memory and acknowledge cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exc_pkg::*;
  logic        ref_clk_in = 1'b0, rst_n_in = 1'b0, mem_ack_in, busy_out, pc_load_out;
  logic        nmi_n_in = 1'b1, nvi_n_in = 1'b1, vi_n_in = 1'b1, abort_n_in = 1'b1;
  logic        instr_valid_in = 1'b0, instr_restricted_in = 1'b0, instr_syscall_in = 1'b0;
  logic        instr_ldps_in = 1'b0, instr_pushpop_in = 1'b0, irq_window_in = 1'b1;
  logic        flags_wr_in = 1'b0, sp_wr_in = 1'b0, psap_wr_in = 1'b0, sema_active_in = 1'b0;
  logic        core_acc_in = 1'b0, core_acc_instr_in = 1'b0, core_acc_stack_in = 1'b0;
  logic        sys_mode_out, stack_reg_ok_out, mem_req_out, mem_we_out;
  logic [3:0]  instr_stack_reg_in = 4'h0;
  logic [7:0]  syscall_code_in = 8'h00, flags_in = 8'h00;
  logic [15:0] ldps_fcw_in = 16'h0000, ldps_pc_in = 16'h0000, short_word_in = 16'h0000;
  logic [15:0] instr_pc_in = 16'h01FE, next_pc_in = 16'h0200, sp_wdata_in = 16'h0000;
  logic [15:0] psap_wdata_in = 16'h0000, mem_rdata_in, pc_new_out, fcw_out, sp_out;
  logic [15:0] short_off_out, mem_addr_out, mem_wdata_out, vec = 16'h0000, ssp;
  logic [6:0]  short_seg_out;
  logic [1:0]  slow = 2'h0;
  bus_st_t     bus_status_out;
  int          miscompares = 0, checks_done = 0;

  cpu_exception_mode_unit cpu_exception_mode_unit_inst (.*);
  exc_far_model exc_far_model_inst (.ref_clk_in, .rst_n_in, .mem_req_in(mem_req_out),
    .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .bus_status_in(bus_status_out), .vector_in(vec), .wait_in(slow),
    .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

  always #12.5 ref_clk_in = ~ref_clk_in;

  task automatic chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic issue(input logic r, c, l, input logic [15:0] f, p);
    @(posedge ref_clk_in);
    instr_valid_in      <= 1'b1;
    instr_restricted_in <= r;
    instr_syscall_in    <= c;
    instr_ldps_in       <= l;
    ldps_fcw_in         <= f;
    ldps_pc_in          <= p;
    irq_window_in       <= !l;
    @(posedge ref_clk_in);
    instr_valid_in      <= 1'b0;
    irq_window_in       <= 1'b1;
  endtask
  task automatic ldps(input logic [15:0] f, p);
    issue(1'b0, 1'b0, 1'b1, f, p);
    @(negedge ref_clk_in);
    chk("ldps_pc", pc_new_out, p);
    chk("ldps_fcw", fcw_out, f);
  endtask
  // Saved words land on the system stack in pc, status, reason order
  task automatic entry(input logic [15:0] off, rsn, spc, ofcw, pcn);
    int n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (pc_load_out !== 1'b1 && n < 300);
    chk("pc_new", pc_new_out, pcn);
    chk("fcw", fcw_out, 16'h4000 + off);
    chk("push_pc", exc_far_model_inst.wdat_q[0], spc);
    chk("push_fcw", exc_far_model_inst.wdat_q[1], ofcw);
    chk("reason", exc_far_model_inst.wdat_q[2], rsn);
    chk("push_adr", exc_far_model_inst.wadr_q[2], ssp - 16'h0006);
    ssp = ssp - 16'h0006;
    chk("sys_sp", sp_out, ssp);
    exc_far_model_inst.wdat_q.delete();
    exc_far_model_inst.wadr_q.delete();
  endtask

  task automatic sc_regs();
    @(posedge ref_clk_in);
    sp_wr_in    <= 1'b1;
    sp_wdata_in <= 16'h0100;
    flags_wr_in <= 1'b1;
    flags_in    <= 8'hA5;
    @(posedge ref_clk_in);
    sp_wr_in    <= 1'b0;
    flags_wr_in <= 1'b0;
    @(negedge ref_clk_in);
    ssp = 16'h0100;
    chk("sp", sp_out, ssp);
    chk("flags", fcw_out, 16'h40A5);
  endtask
  task automatic sc_nmi();
    @(posedge ref_clk_in);
    vec      <= 16'h1234;
    nmi_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    nmi_n_in <= 1'b1;
    entry(PSA_NMI, 16'h1234, 16'h0200, 16'h40A5, 16'h4016);
  endtask
  task automatic sc_vi();
    ldps(16'h5000, 16'h0300);
    @(posedge ref_clk_in);
    vec     <= 16'h1205;
    vi_n_in <= 1'b0;
    slow    <= 2'h2;
    entry(PSA_VI, 16'h1205, 16'h0200, 16'h5000, 16'h402A);
    @(posedge ref_clk_in);
    vi_n_in <= 1'b1;
    slow    <= 2'h0;
  endtask
  task automatic sc_nvi();
    @(posedge ref_clk_in);
    nvi_n_in <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk("masked", {15'h0000, busy_out}, 16'h0000);
    chk("masked_push", 16'(exc_far_model_inst.wdat_q.size()), 16'h0000);
    ldps(16'h4800, 16'h0310);
    entry(PSA_NVI, 16'h1205, 16'h0200, 16'h4800, 16'h401A);
    @(posedge ref_clk_in);
    nvi_n_in <= 1'b1;
  endtask
  task automatic sc_syscall();
    @(posedge ref_clk_in);
    syscall_code_in <= 8'h33;
    issue(1'b0, 1'b1, 1'b0, 16'h0000, 16'h0000);
    entry(PSA_SYSCALL, {RSN_SC_HI, 8'h33}, 16'h0200, 16'h4018, 16'h400E);
  endtask
  task automatic sc_priv();
    ldps(16'h0000, 16'h0400);
    @(posedge ref_clk_in);
    sp_wr_in    <= 1'b1;
    sp_wdata_in <= 16'h0800;
    @(posedge ref_clk_in);
    sp_wr_in    <= 1'b0;
    issue(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000);
    entry(PSA_PRIV, RSN_PRIV, 16'h01FE, 16'h0000, 16'h400A);
    ldps(16'h0000, 16'h0400);
    chk("user_sp", sp_out, 16'h0800);
    issue(1'b0, 1'b0, 1'b1, 16'h4000, 16'h0000);
    entry(PSA_PRIV, RSN_PRIV, 16'h01FE, 16'h0000, 16'h400A);
  endtask
  task automatic sc_abort();
    @(posedge ref_clk_in);
    slow          <= 2'h1;
    psap_wr_in    <= 1'b1;
    psap_wdata_in <= 16'h0100;
    abort_n_in    <= 1'b0;
    @(posedge ref_clk_in);
    psap_wr_in    <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    abort_n_in <= 1'b1;
    // Moved status area shifts both status and handler reads
    entry(PSA_ABORT + 16'h0100, RSN_ABORT, 16'h01FE, 16'h4008, 16'h4106);
  endtask
  task automatic sc_status();
    bus_st_t exp [5] = '{BST_IDLE, BST_DATA, BST_STACK, BST_INSTR, BST_SEMA};
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk_in);
      core_acc_in        <= i inside {[1:4]};
      core_acc_stack_in  <= i == 2;
      core_acc_instr_in  <= i == 3;
      sema_active_in     <= i == 4;
      instr_pushpop_in   <= 1'b1;
      instr_stack_reg_in <= i[3:0];
      short_word_in      <= 16'h5AC3;
      @(negedge ref_clk_in);
      chk("bus_st", {12'h000, bus_status_out}, {12'h000, exp[i]});
      chk("stk_ok", {15'h0000, stack_reg_ok_out}, {15'h0000, i != 0});
    end
    chk("short_off", short_off_out, 16'h00C3);
    chk("short_seg", {9'h000, short_seg_out}, 16'h005A);
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    sc_regs();
    sc_nmi();
    sc_vi();
    sc_nvi();
    sc_syscall();
    sc_priv();
    sc_abort();
    sc_status();
    report_and_stop();
  end
  // About 160 cycles expected; a hang stops well past that
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
endmodule
